// *** shared/sif_irq_defines.vh ***
`ifndef SIF_IRQ_DEFINES_VH
`define SIF_IRQ_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SIF_OFS_STATUS 4'h0
`define SIF_OFS_CLEAR 4'h4
`define SIF_OFS_ENABLE 4'h8
`define SIF_OFS_CTRL 4'hc

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SIF_CTRL_FE_SEL_LO 0
`define SIF_CTRL_FE_SEL_HI 2
`define SIF_CTRL_IS1_LO 3
`define SIF_CTRL_IS1_HI 4
`define SIF_CTRL_IS2_LO 5
`define SIF_CTRL_IS2_HI 6
`define SIF_CTRL_CNT1_INC 7
`define SIF_CTRL_CNT1_DEC 8
`define SIF_CTRL_CNT2_DEC 9

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define SIF_NUM_FLAGS 7
`define SIF_FLAGS_RST 7'h00
`define SIF_CTRL_RST 10'h000
`define SIF_CNT_RST 8'h00

// ----------------------------------------
// Flag positions
// ----------------------------------------
`define SIF_FLG_FE 0
`define SIF_FLG_STOP 1
`define SIF_FLG_START 2
`define SIF_FLG_CNT1 3
`define SIF_FLG_CNT2 4
`define SIF_FLG_Q6 5
`define SIF_FLG_Q7 6

// ----------------------------------------
// State byte bits
// ----------------------------------------
`define SIF_Q1 1
`define SIF_Q2 2
`define SIF_Q6 6
`define SIF_Q7 7

`endif

// *** src/sif_interval_det.v ***
`timescale 1ns/100ps

// ----------------------------------------
// Interval crossing detector with hysteresis
// ----------------------------------------
module sif_interval_det #(
	parameter CNT_W = 8
) (
	input wire clk,
	input wire reset_n,
	input wire [CNT_W-1:0] count,
	input wire [1:0] interval_sel,
	output reg hit_q
);

	reg armed_q;
	reg [CNT_W-1:0] level_q;
	reg [CNT_W-1:0] mask;
	reg at_level;
	reg away;

	// Interval 4, 16, 64 or 256 counts
	always @* begin
		case (interval_sel)
			2'h0: mask = 8'h03;
			2'h1: mask = 8'h0f;
			2'h2: mask = 8'h3f;
			default: mask = 8'hff;
		endcase
		at_level = ((count & mask) == {CNT_W{1'b0}});
		// Rearm only once two steps away from the last level hit
		away = ((count - level_q) != 8'h00) && ((count - level_q) != 8'h01) &&
			((count - level_q) != 8'hff);
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			armed_q <= 1'b0;
			level_q <= 8'h00;
			hit_q <= 1'b0;
		end else begin
			hit_q <= 1'b0;
			if (armed_q && at_level) begin
				hit_q <= 1'b1;
				armed_q <= 1'b0;
				level_q <= count;
			end else if (!armed_q && away) begin
				armed_q <= 1'b1;
			end
		end
	end

endmodule // sif_interval_det

// *** src/sif_irq_ctrl.v ***
`timescale 1ns/100ps
`include "sif_irq_defines.vh"

module sif_irq_ctrl #(
	parameter FE_W = 8,
	parameter CNT_W = 8
) (
	input wire clk,
	input wire reset_n,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire global_interrupt_enable,
	input wire [FE_W-1:0] front_end_output_bit,
	input wire sequence_stop_signal,
	input wire sequence_start,
	input wire state_load,
	input wire [7:0] state_byte,
	output reg irq_q,
	output reg [CNT_W-1:0] rotation_counter_one,
	output reg [CNT_W-1:0] rotation_counter_two
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [6:0] flags_q;
	reg [6:0] flags_d;
	reg [6:0] enable_q;
	reg [6:0] enable_d;
	reg [9:0] ctrl_q;
	reg stop_prev_q;
	reg fe_prev_q;
	reg ack_q;
	reg [6:0] clear_req;
	reg [6:0] events;
	wire [2:0] front_end_flag_source_select;
	wire [1:0] counter_one_interval_select;
	wire [1:0] counter_two_interval_select;
	wire fe_sel_bit;
	wire cnt1_hit;
	wire cnt2_hit;
	wire inc1;
	wire dec1;
	wire dec2;
	wire acc;

	assign front_end_flag_source_select = ctrl_q[`SIF_CTRL_FE_SEL_HI:`SIF_CTRL_FE_SEL_LO];
	assign counter_one_interval_select = ctrl_q[`SIF_CTRL_IS1_HI:`SIF_CTRL_IS1_LO];
	assign counter_two_interval_select = ctrl_q[`SIF_CTRL_IS2_HI:`SIF_CTRL_IS2_LO];

	// Out-of-range select reads as zero, so no events
	assign fe_sel_bit = (front_end_flag_source_select < FE_W) ?
		front_end_output_bit[front_end_flag_source_select] : 1'b0;

	// ----------------------------------------
	// Avalon slave: one wait cycle per access
	// ----------------------------------------
	// The first cycle of every access holds waitrequest; the answer comes on the next edge.
	assign acc = (avs_read || avs_write) && !ack_q;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_q <= acc;
			avs_waitrequest <= !acc;
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= 32'h00000000;
		end else if (acc && avs_read) begin
			if (avs_address == `SIF_OFS_STATUS) begin
				avs_readdata <= {25'h0000000, flags_q};
			end else if (avs_address == `SIF_OFS_ENABLE) begin
				avs_readdata <= {25'h0000000, enable_q};
			end else if (avs_address == `SIF_OFS_CTRL) begin
				avs_readdata <= {6'h00, rotation_counter_two, rotation_counter_one, ctrl_q};
			end else begin
				avs_readdata <= 32'h00000000;
			end
		end
	end

	// Writes take effect at the edge where waitrequest is seen low
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_q <= `SIF_FLAGS_RST;
			ctrl_q <= `SIF_CTRL_RST;
		end else if (ack_q && avs_write) begin
			if (avs_address == `SIF_OFS_ENABLE) begin
				enable_q <= avs_writedata[6:0];
			end else if (avs_address == `SIF_OFS_CTRL) begin
				ctrl_q <= avs_writedata[9:0];
			end
		end
	end

	always @* begin
		clear_req = 7'h00;
		if (ack_q && avs_write && (avs_address == `SIF_OFS_CLEAR)) begin
			clear_req = avs_writedata[6:0];
		end
	end

	// Next enable, so a masking write gates the interrupt at its own edge
	always @* begin
		enable_d = enable_q;
		if (ack_q && avs_write && (avs_address == `SIF_OFS_ENABLE)) begin
			enable_d = avs_writedata[6:0];
		end
	end

	// ----------------------------------------
	// Rotation counters
	// ----------------------------------------
	assign inc1 = state_load && ctrl_q[`SIF_CTRL_CNT1_INC] && state_byte[`SIF_Q1];
	assign dec1 = state_load && ctrl_q[`SIF_CTRL_CNT1_DEC] && state_byte[`SIF_Q2];
	assign dec2 = state_load && ctrl_q[`SIF_CTRL_CNT2_DEC] && state_byte[`SIF_Q2];

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rotation_counter_one <= `SIF_CNT_RST;
			rotation_counter_two <= `SIF_CNT_RST;
		end else begin
			// Both directions at once cancel out
			if (inc1 && !dec1) begin
				rotation_counter_one <= rotation_counter_one + 8'h01;
			end else if (dec1 && !inc1) begin
				rotation_counter_one <= rotation_counter_one - 8'h01;
			end
			if (dec2) begin
				rotation_counter_two <= rotation_counter_two - 8'h01;
			end
		end
	end

	sif_interval_det #(
		.CNT_W(CNT_W)
	) u_det_one (
		.clk(clk),
		.reset_n(reset_n),
		.count(rotation_counter_one),
		.interval_sel(counter_one_interval_select),
		.hit_q(cnt1_hit)
	);

	sif_interval_det #(
		.CNT_W(CNT_W)
	) u_det_two (
		.clk(clk),
		.reset_n(reset_n),
		.count(rotation_counter_two),
		.interval_sel(counter_two_interval_select),
		.hit_q(cnt2_hit)
	);

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_prev_q <= 1'b0;
			fe_prev_q <= 1'b0;
		end else begin
			stop_prev_q <= sequence_stop_signal;
			fe_prev_q <= fe_sel_bit;
		end
	end

	always @* begin
		events = 7'h00;
		// Rising edge so a held comparator level sets the flag once per pulse
		events[`SIF_FLG_FE] = fe_sel_bit && !fe_prev_q;
		events[`SIF_FLG_STOP] = sequence_stop_signal && !stop_prev_q;
		events[`SIF_FLG_START] = sequence_start;
		events[`SIF_FLG_CNT1] = cnt1_hit;
		events[`SIF_FLG_CNT2] = cnt2_hit;
		events[`SIF_FLG_Q6] = state_load && state_byte[`SIF_Q6];
		events[`SIF_FLG_Q7] = state_load && state_byte[`SIF_Q7];
	end

	// ----------------------------------------
	// Sticky flags and interrupt
	// ----------------------------------------
	always @* begin
		// Set wins over a clear in the same cycle
		flags_d = (flags_q & ~clear_req) | events;
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_q <= `SIF_FLAGS_RST;
			irq_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			irq_q <= global_interrupt_enable && ((flags_d & enable_d) != 7'h00);
		end
	end


endmodule // sif_irq_ctrl

// *** sim/sif_irq_ctrl_sva.sv ***
`timescale 1ns/100ps
// ----
// Bus, interrupt and counter checks
// ----
module sif_irq_ctrl_sva #(
	parameter FE_W = 8,
	parameter CNT_W = 8
) (
	input wire clk,
	input wire reset_n,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire global_interrupt_enable,
	input wire state_load,
	input wire [7:0] state_byte,
	input wire irq_q,
	input wire [CNT_W-1:0] rotation_counter_one,
	input wire [CNT_W-1:0] rotation_counter_two
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire wr_done = avs_write & ~avs_waitrequest;
	wait_answer_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	one_wait_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	gie_gates_a: assert property (!global_interrupt_enable |=> !irq_q)
		else $error("irq without global enable");
	flag_sticky_a: assert property (irq_q && global_interrupt_enable && !wr_done |=> irq_q)
		else $error("irq dropped without a write");
	cnt1_step_a: assert property (!$stable(rotation_counter_one) |-> $past(state_load))
		else $error("counter one moved without a state load");
	cnt1_up_a: assert property (rotation_counter_one == $past(rotation_counter_one) + 1'b1
		|-> $past(state_load && state_byte[1]))
		else $error("counter one rose without Q1");
	cnt1_down_a: assert property (rotation_counter_one == $past(rotation_counter_one) - 1'b1
		|-> $past(state_load && state_byte[2]))
		else $error("counter one fell without Q2");
	cnt2_down_a: assert property (!$stable(rotation_counter_two) |-> $past(state_byte[2])
		&& rotation_counter_two == $past(rotation_counter_two) - 1'b1)
		else $error("counter two moved wrongly");
endmodule // sif_irq_ctrl_sva
bind sif_irq_ctrl sif_irq_ctrl_sva #(.FE_W(FE_W), .CNT_W(CNT_W)) u_sva (.clk, .reset_n,
	.avs_read, .avs_write, .avs_waitrequest, .global_interrupt_enable, .state_load,
	.state_byte, .irq_q, .rotation_counter_one, .rotation_counter_two);

// *** sim/sif_quad_model.sv ***
`timescale 1ns/100ps
// ----
// Quadrature state table source
// ----
module sif_quad_model (
	input wire clk,
	input wire reset_n,
	input wire [1:0] pair,
	input wire mark7,
	output reg state_load,
	output reg [7:0] state_byte
);
	reg [1:0] prev_q;
	wire err = (prev_q ^ pair) == 2'b11;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= 2'b00;
			state_load <= 1'b0;
			state_byte <= 8'h00;
		end else begin
			prev_q <= pair;
			state_load <= pair != prev_q;
			// Byte is garbage outside a load
			state_byte <= (pair == prev_q) ? ~state_byte : {mark7, err, 2'b00, pair[1],
				prev_q == 2'b00 && pair == 2'b10, prev_q == 2'b00 && pair == 2'b01,
				pair[0]};
		end
	end
endmodule // sif_quad_model

// *** sim/scan_interface_interrupt_flags_bench.sv ***
`timescale 1ns/100ps
module scan_interface_interrupt_flags_bench;
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg [3:0] avs_address = 4'h0;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h0;
	reg global_interrupt_enable = 1'b0;
	reg [7:0] front_end_output_bit = 8'h00;
	reg sequence_stop_signal = 1'b0;
	reg sequence_start = 1'b0;
	reg [1:0] pair = 2'b00;
	reg mark7 = 1'b0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, irq_q, state_load;
	wire [7:0] state_byte, rotation_counter_one, rotation_counter_two;
	reg [31:0] rdat;
	integer n_mismatch = 0;
	integer num_checks = 0;
	integer k;
	initial forever #12.5 clk = ~clk;
	sif_irq_ctrl u_dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .global_interrupt_enable, .front_end_output_bit,
		.sequence_stop_signal, .sequence_start, .state_load, .state_byte, .irq_q,
		.rotation_counter_one, .rotation_counter_two);
	sif_quad_model u_quad (.clk, .reset_n, .pair, .mark7, .state_load, .state_byte);
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [63:0] what, input [31:0] exp, input [31:0] got);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// ----
	// Bus access, held until waitrequest is seen low
	// ----
	task acc(input w, input [3:0] a, input [31:0] d);
		integer i;
		begin
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= w;
			avs_read <= !w;
			i = 0;
			@(posedge clk);
			while (avs_waitrequest !== 1'b0 && i < 20) begin
				@(posedge clk);
				i = i + 1;
			end
			rdat = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			if (i == 20) begin
				n_mismatch = n_mismatch + 1;
				end_of_test;
			end
			@(posedge clk);
		end
	endtask
	task rd_chk(input [63:0] what, input [3:0] a, input [31:0] exp);
		begin
			acc(1'b0, a, 32'h0);
			chk(what, exp, rdat);
		end
	endtask
	task fire(input integer f);
		begin
			case (f)
				0: front_end_output_bit <= 8'h09;
				1: sequence_stop_signal <= 1'b1;
				2: sequence_start <= 1'b1;
				3: repeat (4) begin pair <= 2'b01; tick(3); pair <= 2'b00; tick(3); end
				4: repeat (4) begin pair <= 2'b10; tick(3); pair <= 2'b00; tick(3); end
				5: pair <= 2'b11;
				6: begin mark7 <= 1'b1; pair <= 2'b01; end
			endcase
			tick(1);
			sequence_stop_signal <= 1'b0;
			sequence_start <= 1'b0;
			mark7 <= 1'b0;
			pair <= 2'b00;
			tick(3);
		end
	endtask
	initial begin
		tick(16);
		reset_n <= 1'b1;
		tick(1);
		rd_chk("status", 4'h0, 32'h0);
		rd_chk("enable", 4'h8, 32'h0);
		rd_chk("ctrl", 4'hc, 32'h0);
		rd_chk("unmapd", 4'h1, 32'h0);
		acc(1'b1, 4'h0, 32'h7f);
		rd_chk("status", 4'h0, 32'h0);
		acc(1'b1, 4'h8, 32'h7f);
		acc(1'b1, 4'hc, 32'h283);
		rd_chk("ctrl", 4'hc, 32'h283);
		rd_chk("clear", 4'h4, 32'h0);
		global_interrupt_enable <= 1'b1;
		front_end_output_bit <= 8'h01;
		tick(3);
		rd_chk("status", 4'h0, 32'h0);
		for (k = 0; k < 7; k = k + 1) begin
			fire(k);
			rd_chk("status", 4'h0, 32'h1 << k);
			chk("irq", 32'h1, irq_q);
			acc(1'b1, 4'h4, 32'h1 << k);
			rd_chk("status", 4'h0, 32'h0);
		end
		chk("cnt1", 32'h5, rotation_counter_one);
		chk("cnt2", 32'hfc, rotation_counter_two);
		// Counter one walks back past its last hit down to the next level
		acc(1'b1, 4'hc, 32'h383);
		fire(4);
		pair <= 2'b10;
		tick(3);
		pair <= 2'b00;
		tick(3);
		rd_chk("status", 4'h0, 32'h18);
		chk("cnt1", 32'h0, rotation_counter_one);
		chk("cnt2", 32'hf7, rotation_counter_two);
		acc(1'b1, 4'h4, 32'h7f);
		// Rock counter one between its last hit level and one above: no second flag
		for (k = 0; k < 4; k = k + 1) begin
			pair <= k[0] ? 2'b10 : 2'b01;
			tick(3);
			pair <= 2'b00;
			tick(3);
		end
		rd_chk("status", 4'h0, 32'h0);
		chk("cnt1", 32'h0, rotation_counter_one);
		// Sixteen-count interval on counter two: f4 is no level, f0 is
		acc(1'b1, 4'hc, 32'h2a3);
		for (k = 0; k < 5; k = k + 1) begin
			pair <= 2'b10;
			tick(3);
			pair <= 2'b00;
			tick(3);
			if (k == 0) rd_chk("status", 4'h0, 32'h0);
		end
		rd_chk("status", 4'h0, 32'h10);
		chk("cnt2", 32'hf0, rotation_counter_two);
		acc(1'b1, 4'h4, 32'h7f);
		fire(2);
		acc(1'b1, 4'h8, 32'h7b);
		chk("irq", 32'h0, irq_q);
		acc(1'b1, 4'h8, 32'h7f);
		chk("irq", 32'h1, irq_q);
		global_interrupt_enable <= 1'b0;
		tick(2);
		chk("irq", 32'h0, irq_q);
		rd_chk("status", 4'h0, 32'h4);
		end_of_test;
	end
endmodule // scan_interface_interrupt_flags_bench
